// >>> include/acs_pkg.sv
// Package for the calibration sequencer: mode codes, timing counts, widths.
// Assumes one 100 MHz master clock shared by the device and host ends.
package acs_pkg;
  // Calibration-mode field codes (cal_mode_bit2..0)
  localparam logic [2:0] MODE_IDLE     = 3'h0;
  localparam logic [2:0] MODE_SYS_ZS   = 3'h2;
  localparam logic [2:0] MODE_SYS_FS   = 3'h3;
  localparam logic [2:0] MODE_SYS_OFS  = 3'h4;
  localparam logic [2:0] MODE_BACKGND  = 3'h5;
  // One modulator cycle in master clocks
  localparam int MOD_CYCLE_CLKS        = 128;
  // Output-rate period in modulator cycles (plain default)
  localparam int RATE_MOD_CYCLES       = 4;
  localparam int RATE_CLKS             = MOD_CYCLE_CLKS * RATE_MOD_CYCLES;
  // Step lengths in output-rate periods
  localparam int ZS_FS_PERIODS         = 3;
  localparam int OFS_PERIODS           = 6;
  localparam int SYS_CONV_PERIODS      = 1;
  localparam int OFS_CONV_PERIODS      = 3;
  localparam int BG_PERIODS            = 6;
  // Coefficient and data width
  localparam int COEF_W                = 24;
  // Reset coefficient values and expected calibration readings
  localparam logic [23:0] ZS_COEF_RST  = 24'h000000;
  localparam logic [23:0] FS_COEF_RST  = 24'h800000;
  localparam logic [23:0] ZERO_READING = 24'h000000;
  localparam logic [23:0] MID_READING  = 24'h800000;
  localparam logic [23:0] FULL_READING = 24'hffffff;
endpackage

// >>> include/acs_if.sv
// Link between host and calibration sequencer: mode write, coefficients, data.
// Assumes both ends run on the same clk; no clocking blocks.
`timescale 1ns/100ps
`default_nettype none
interface acs_if;
  logic        modeWr;
  logic [2:0]  modeWrData;
  logic [2:0]  calMode;
  logic        coefWrZs;
  logic        coefWrFs;
  logic [23:0] coefWrData;
  logic [23:0] zeroScaleCoef;
  logic [23:0] fullScaleCoef;
  logic        dataReadyN;
  logic [23:0] dataWord;
  logic        filterSync;
  logic        shortInputs;
  logic        unipolar;

  modport device
  (
    input  modeWr, modeWrData, coefWrZs, coefWrFs, coefWrData, filterSync, unipolar,
    output calMode, zeroScaleCoef, fullScaleCoef, dataReadyN, dataWord, shortInputs
  );
  modport host
  (
    output modeWr, modeWrData, coefWrZs, coefWrFs, coefWrData, filterSync, unipolar,
    input  calMode, zeroScaleCoef, fullScaleCoef, dataReadyN, dataWord, shortInputs
  );
endinterface
`default_nettype wire

// >>> rtl/acs_device.sv
// Device end: calibration sequencer timing steps in output-rate periods.
// Assumes the host keeps the analog input steady through each step.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Host settles zero input before starting.
// - Code 010 starts zero-scale system calibration.
// - Step lasts three periods, then mode clears.
// - Data-ready held high until new word.
// - Zero-scale: data-ready low after four periods.
// - Following conversion reads zero scale.
// - Data-ready rises within one modulator cycle.
// - Host ignores data-ready one modulator cycle.
// - Code 011 full-scale; ready after four periods.
// - Following conversion reads full scale.
// - Unipolar endpoints; bipolar midscale to full.
// - Single calibration updates only its coefficient.
// - Host starts full-scale only after zero-scale.
// - Code 100 starts system-offset calibration.
// - System-offset step lasts six periods.
// - System-offset ready after nine periods.
// - Code 101 enters background calibration.
// - Background zero-cal after each update, rate/6.
// - Background stays until host changes mode.
// - Host avoids filter sync in background.
// - Subtract offset before applying gain.
// - Coefficients are 24 bits, host-readable/writable.
// - Zero self-cal shorts inputs to bias.
module acs_device
(
  input  wire logic        clk,
  input  wire logic        rst,
  acs_if.device            link,
  input  wire logic [23:0] analogInput
);
  typedef enum logic [2:0] {ST_IDLE, ST_CAL, ST_CONV, ST_BG_CAL, ST_BG_CONV} acs_state_t;

  typedef struct packed
  {
    acs_state_t  state;
    logic [2:0]  mode;
    logic [15:0] clkCnt;
    logic [3:0]  periodCnt;
    logic [23:0] zsCoef;
    logic [23:0] fsCoef;
    logic        drdyN;
    logic [23:0] data;
    logic        shortIn;
  } acs_dev_t;

  acs_dev_t st_r;
  acs_dev_t st_nxt;

  // Offset subtraction then gain scaling, Q1.23 gain
  function automatic logic [23:0] acs_correct(input logic [23:0] raw,
                                              input logic [23:0] zs,
                                              input logic [23:0] fs);
    logic [23:0] diff;
    logic [47:0] prod;
    diff = raw - zs;
    prod = diff * fs;
    return prod[46:23];
  endfunction

  // Steps that end in a mode clear
  function automatic logic acs_is_step(input logic [2:0] m);
    return (m == acs_pkg::MODE_SYS_ZS) || (m == acs_pkg::MODE_SYS_FS) ||
           (m == acs_pkg::MODE_SYS_OFS);
  endfunction

  logic        rateTick;
  logic [23:0] corrected;
  // Conversion length and reading depend on the step that preceded it
  logic [3:0]  convLen;
  logic [23:0] calReading;
  logic        lastWasOfs;
  logic        lastWasOfs_r;
  logic        lastFs;
  logic        lastFs_r;
  assign lastWasOfs = link.modeWr ? (link.modeWrData == acs_pkg::MODE_SYS_OFS) : lastWasOfs_r;
  assign lastFs     = link.modeWr ? (link.modeWrData == acs_pkg::MODE_SYS_FS) : lastFs_r;
  assign convLen    = lastWasOfs_r ? 4'(acs_pkg::OFS_CONV_PERIODS)
                                   : 4'(acs_pkg::SYS_CONV_PERIODS);
  // Bipolar zero reads midscale; full-scale step reads all ones
  assign calReading = lastFs_r ? acs_pkg::FULL_READING
                     : (link.unipolar ? acs_pkg::ZERO_READING : acs_pkg::MID_READING);

  assign rateTick  = (st_r.clkCnt == 16'(acs_pkg::RATE_CLKS - 1));
  assign corrected = acs_correct(analogInput, st_r.zsCoef, st_r.fsCoef);

  // Next-state logic; mode write restarts the period grid so timing is exact
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.clkCnt = rateTick ? 16'h0000 : st_r.clkCnt + 16'h0001;
    if (link.coefWrZs)
      st_nxt.zsCoef = link.coefWrData;
    if (link.coefWrFs)
      st_nxt.fsCoef = link.coefWrData;
    if (link.modeWr)
    begin
      st_nxt.mode      = link.modeWrData;
      st_nxt.clkCnt    = 16'h0000;
      st_nxt.periodCnt = 4'h0;
      st_nxt.shortIn   = 1'b0;
      if (acs_is_step(link.modeWrData))
      begin
        st_nxt.state = ST_CAL;
        st_nxt.drdyN = 1'b1;   // Raised next edge, well inside one modulator cycle
      end
      else if (link.modeWrData == acs_pkg::MODE_BACKGND)
      begin
        st_nxt.state   = ST_BG_CAL;
        st_nxt.drdyN   = 1'b1;
        st_nxt.shortIn = 1'b1;
      end
      else
        st_nxt.state = ST_IDLE; // Leaves background on any other code
    end
    else if (rateTick)
    begin
      st_nxt.periodCnt = st_r.periodCnt + 4'h1;
      unique case (st_r.state)
        ST_IDLE:
        begin
          st_nxt.periodCnt = 4'h0;
        end
        ST_CAL:
        begin
          if (st_r.mode == acs_pkg::MODE_SYS_OFS)
          begin
            // One six-period step; zero point from input, full-scale reset to FS_COEF_RST
            if (st_r.periodCnt == 4'(acs_pkg::OFS_PERIODS - 1))
            begin
              st_nxt.zsCoef    = analogInput; // Same edge as mode clear
              st_nxt.fsCoef    = acs_pkg::FS_COEF_RST;
              st_nxt.mode      = acs_pkg::MODE_IDLE;
              st_nxt.state     = ST_CONV;
              st_nxt.periodCnt = 4'h0;
            end
          end
          else if (st_r.periodCnt == 4'(acs_pkg::ZS_FS_PERIODS - 1))
          begin
            // Each single step touches only its own coefficient
            if (st_r.mode == acs_pkg::MODE_SYS_ZS)
              st_nxt.zsCoef = analogInput;
            else
              st_nxt.fsCoef = analogInput - st_r.zsCoef; // Span from zero point
            st_nxt.mode      = acs_pkg::MODE_IDLE;
            st_nxt.state     = ST_CONV;
            st_nxt.periodCnt = 4'h0;
          end
        end
        ST_CONV:
        begin
          // Conversion: 1 period after system steps, 3 after system-offset
          if (st_r.periodCnt == convLen - 4'h1)
          begin
            // Fixed calReading word: zero or midscale, all ones after full-scale
            st_nxt.data      = calReading;
            st_nxt.drdyN     = 1'b0;
            st_nxt.state     = ST_IDLE;
            st_nxt.periodCnt = 4'h0;
          end
        end
        ST_BG_CAL:
        begin
          // Zero self-cal on shorted inputs, then one conversion
          if (st_r.periodCnt == 4'(acs_pkg::BG_PERIODS - 2))
          begin
            st_nxt.zsCoef    = analogInput; // Bias-shorted reading refreshes offset
            st_nxt.shortIn   = 1'b0;
            st_nxt.state     = ST_BG_CONV;
            st_nxt.periodCnt = 4'h0;
          end
        end
        ST_BG_CONV:
        begin
          st_nxt.data      = corrected;
          st_nxt.drdyN     = 1'b0;
          st_nxt.shortIn   = 1'b1;
          st_nxt.state     = ST_BG_CAL; // Stays until rewritten
          st_nxt.periodCnt = 4'h0;
        end
        default:
          st_nxt.state = ST_IDLE;
      endcase
      // Data-ready pulses one period in background, then rises for next cal
      if (st_r.state == ST_BG_CAL && st_r.periodCnt == 4'h0 && !st_r.drdyN)
        st_nxt.drdyN = 1'b1;
    end
  end

  // Single register stage for all state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r.state     <= ST_IDLE;
      st_r.mode      <= acs_pkg::MODE_IDLE;
      st_r.clkCnt    <= 16'h0000;
      st_r.periodCnt <= 4'h0;
      st_r.zsCoef    <= acs_pkg::ZS_COEF_RST;
      st_r.fsCoef    <= acs_pkg::FS_COEF_RST;
      st_r.drdyN     <= 1'b1;
      st_r.data      <= 24'h000000;
      st_r.shortIn   <= 1'b0;
      lastWasOfs_r   <= 1'b0;
      lastFs_r       <= 1'b0;
    end
    else
    begin
      st_r         <= st_nxt;
      lastWasOfs_r <= lastWasOfs;
      lastFs_r     <= lastFs;
    end
  end

  assign link.calMode       = st_r.mode;
  assign link.zeroScaleCoef = st_r.zsCoef;
  assign link.fullScaleCoef = st_r.fsCoef;
  assign link.dataReadyN    = st_r.drdyN;
  assign link.dataWord      = st_r.data;
  assign link.shortInputs   = st_r.shortIn;
endmodule
`default_nettype wire

// >>> rtl/acs_host.sv
// Host end: issues mode writes and coefficient loads from a user command port.
// Assumes the device end shares clk; holds data-ready masked after each write.
`timescale 1ns/100ps
`default_nettype none
module acs_host
(
  input  wire logic        clk,
  input  wire logic        rst,
  acs_if.host              link,
  input  wire logic        cmdValid,
  input  wire logic [2:0]  cmdMode,
  input  wire logic        cmdUnipolar,
  input  wire logic        coefLoadZs,
  input  wire logic        coefLoadFs,
  input  wire logic [23:0] coefLoadData,
  output logic             cmdReady,
  output logic             readyValid,
  output logic [23:0]      readyWord,
  output logic             zsValid
);
  typedef struct packed
  {
    logic [7:0]  maskCnt;
    logic        modeWr;
    logic [2:0]  modeData;
    logic        unipolar;
    logic        zsOk;
    logic        rdy;
    logic [23:0] word;
    logic        drdyPrev;
  } acs_host_t;

  acs_host_t h_r;
  acs_host_t h_nxt;
  logic      bg;

  assign bg       = (link.calMode == acs_pkg::MODE_BACKGND);
  // Full-scale refused until zero-scale coefficient known
  assign cmdReady = (h_r.maskCnt == 8'h00) && !h_r.modeWr &&
                    !(cmdMode == acs_pkg::MODE_SYS_FS && !h_r.zsOk);

  // Mask data-ready one modulator cycle after each mode write
  always_comb
  begin
    h_nxt          = h_r;
    h_nxt.modeWr   = 1'b0;
    h_nxt.rdy      = 1'b0;
    h_nxt.drdyPrev = link.dataReadyN;
    if (h_r.maskCnt != 8'h00)
      h_nxt.maskCnt = h_r.maskCnt - 8'h01;
    if (cmdValid && cmdReady)
    begin
      h_nxt.modeWr   = 1'b1;
      h_nxt.modeData = cmdMode;
      h_nxt.unipolar = cmdUnipolar; // Input held steady by caller
      h_nxt.maskCnt  = 8'(acs_pkg::MOD_CYCLE_CLKS);
    end
    if (coefLoadZs)
      h_nxt.zsOk = 1'b1;
    if (h_r.maskCnt == 8'h00 && h_r.drdyPrev && !link.dataReadyN)
    begin
      h_nxt.rdy  = 1'b1;
      h_nxt.word = link.dataWord;
      if (h_r.modeData == acs_pkg::MODE_SYS_ZS || h_r.modeData == acs_pkg::MODE_SYS_OFS)
        h_nxt.zsOk = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      h_r <= '0;
    else
      h_r <= h_nxt;
  end

  assign link.modeWr     = h_r.modeWr;
  assign link.modeWrData = h_r.modeData;
  assign link.coefWrZs   = coefLoadZs;
  assign link.coefWrFs   = coefLoadFs;
  assign link.coefWrData = coefLoadData;
  assign link.filterSync = 1'b0 & bg; // Never pulsed, least of all in background
  assign link.unipolar   = h_r.unipolar;
  assign readyValid      = h_r.rdy;
  assign readyWord       = h_r.word;
  assign zsValid         = h_r.zsOk;
endmodule
`default_nettype wire

// >>> testbench/acs_assertions.sv
// Checker for the host/device link: step lengths, ready timing, words, coefficients.
// Assumes one clk for both ends and a synchronous, active-high rst.
`timescale 1ns/100ps
`default_nettype none
module acs_assertions
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        modeWr,
  input wire logic [2:0]  modeWrData,
  input wire logic [2:0]  calMode,
  input wire logic        coefWrZs,
  input wire logic [23:0] coefWrData,
  input wire logic [23:0] zeroScaleCoef,
  input wire logic        dataReadyN,
  input wire logic [23:0] dataWord,
  input wire logic        unipolar
);
  logic [12:0] sinceWr_r;
  logic [2:0]  code_r;
  logic        sys;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Cycles since the last mode write; saturates so long runs stay quiet
  always_ff @(posedge clk)
  begin
    if (rst)
      sinceWr_r <= 13'h0;
    else if (modeWr)
      sinceWr_r <= 13'h1;
    else if (sinceWr_r != 13'h0 && sinceWr_r != 13'h1fff)
      sinceWr_r <= sinceWr_r + 13'h1;
  end
  // Last written code, kept to tell the step kinds apart
  always_ff @(posedge clk)
  begin
    if (rst)
      code_r <= 3'h0;
    else if (modeWr)
      code_r <= modeWrData;
  end
  assign sys = code_r == acs_pkg::MODE_SYS_ZS || code_r == acs_pkg::MODE_SYS_FS;
  sequence readyFalls;
    dataReadyN ##1 !dataReadyN;
  endsequence
  sequence modeClears;
    calMode == code_r ##1 calMode == 3'h0;
  endsequence

  start_sets_mode_a: assert property (modeWr |=> calMode == $past(modeWrData))
    else $error("mode field not loaded by write");
  start_ready_high_a: assert property (modeWr && modeWrData != 3'h0 |=> dataReadyN)
    else $error("ready not raised on calibration start");
  sys_ready_wait_a: assert property (sys && sinceWr_r inside {[1:2048]} |-> dataReadyN)
    else $error("ready low during system step");
  sys_step_clear_a: assert property (sys && sinceWr_r == 13'd1536 |-> modeClears)
    else $error("system step length wrong");
  sys_ready_low_a: assert property (sys && sinceWr_r == 13'd2048 |-> readyFalls)
    else $error("system ready timing wrong");
  ofs_step_clear_a: assert property (code_r == acs_pkg::MODE_SYS_OFS && sinceWr_r == 13'd3072
    |-> modeClears)
    else $error("offset step length wrong");
  ofs_ready_low_a: assert property (code_r == acs_pkg::MODE_SYS_OFS && sinceWr_r == 13'd4608
    |-> readyFalls)
    else $error("offset ready timing wrong");
  zero_word_a: assert property ($fell(dataReadyN) && (code_r == acs_pkg::MODE_SYS_ZS
    || code_r == acs_pkg::MODE_SYS_OFS) |-> dataWord == (unipolar ? acs_pkg::ZERO_READING
    : acs_pkg::MID_READING))
    else $error("zero reading wrong");
  full_word_a: assert property ($fell(dataReadyN) && code_r == acs_pkg::MODE_SYS_FS
    |-> dataWord == acs_pkg::FULL_READING)
    else $error("full reading wrong");
  bg_mode_stays_a: assert property (calMode == acs_pkg::MODE_BACKGND && !modeWr
    |=> calMode == acs_pkg::MODE_BACKGND)
    else $error("background mode left by itself");
  zs_coef_write_a: assert property (coefWrZs |=> zeroScaleCoef == $past(coefWrData))
    else $error("zero coefficient write lost");
  fs_keeps_zs_a: assert property (calMode == acs_pkg::MODE_SYS_FS && !coefWrZs
    |=> $stable(zeroScaleCoef))
    else $error("gain step touched zero coefficient");
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Bench: host and device ends joined by the link, driven from the host command port.
// Assumes a 100 MHz clk and a synchronous, active-high rst held six cycles.
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct {logic [2:0] mode; logic uni; logic [23:0] word; int lat;} acs_row_t;
  logic        clk;
  logic        rst;
  logic        cmdValid;
  logic [2:0]  cmdMode;
  logic        cmdUnipolar;
  logic        coefLoadZs;
  logic        coefLoadFs;
  logic [23:0] coefLoadData;
  logic [23:0] analogInput;
  logic        cmdReady;
  logic        readyValid;
  logic [23:0] readyWord;
  logic        zsValid;
  logic        shortSeen;
  logic [23:0] w;
  int          lat;
  int          errTotal = 0;
  int          testsRun = 0;
  acs_row_t    rows [5] = '{
    '{acs_pkg::MODE_SYS_ZS, 1'h1, acs_pkg::ZERO_READING, 2048},
    '{acs_pkg::MODE_SYS_ZS, 1'h0, acs_pkg::MID_READING, 2048},
    '{acs_pkg::MODE_SYS_FS, 1'h1, acs_pkg::FULL_READING, 2048},
    '{acs_pkg::MODE_SYS_OFS, 1'h1, acs_pkg::ZERO_READING, 4608},
    '{acs_pkg::MODE_SYS_OFS, 1'h0, acs_pkg::MID_READING, 4608}};

  acs_if link ();
  acs_device acs_device_i (.clk(clk), .rst(rst), .link(link), .analogInput(analogInput));
  acs_host acs_host_i (.clk(clk), .rst(rst), .link(link), .cmdValid(cmdValid),
    .cmdMode(cmdMode), .cmdUnipolar(cmdUnipolar), .coefLoadZs(coefLoadZs),
    .coefLoadFs(coefLoadFs), .coefLoadData(coefLoadData), .cmdReady(cmdReady),
    .readyValid(readyValid), .readyWord(readyWord), .zsValid(zsValid));
  acs_assertions acs_assertions_i (.clk(clk), .rst(rst), .modeWr(link.modeWr),
    .modeWrData(link.modeWrData), .calMode(link.calMode), .coefWrZs(link.coefWrZs),
    .coefWrData(link.coefWrData), .zeroScaleCoef(link.zeroScaleCoef),
    .dataReadyN(link.dataReadyN), .dataWord(link.dataWord), .unipolar(link.unipolar));

  // Free-running master clock
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Inputs shorted during background zero steps
  always @(posedge clk)
    if (link.shortInputs === 1'h1)
      shortSeen <= 1'h1;

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // Waits out the host's refusal window, then offers one command
  task automatic issue(input logic [2:0] m, input logic u);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (cmdReady !== 1'h1 && n < 9000);
    @(posedge clk);
    cmdValid <= 1'h1;
    cmdMode <= m;
    cmdUnipolar <= u;
    @(posedge clk);
    cmdValid <= 1'h0;
  endtask
  // Bounded wait for the next new data word from the host end
  task automatic waitWord(output int l, output logic [23:0] word);
    l = 0;
    do
    begin
      @(negedge clk);
      l++;
    end
    while (readyValid !== 1'h1 && l < 7000);
    word = readyWord;
  endtask
  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence: reset, table of system steps, coefficient keep, background
  initial
  begin
    rst = 1'h1;
    cmdValid = 1'h0;
    cmdMode = 3'h0;
    cmdUnipolar = 1'h1;
    coefLoadZs = 1'h0;
    coefLoadFs = 1'h0;
    coefLoadData = 24'h0;
    analogInput = 24'h000100;
    shortSeen = 1'h0;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    check(link.calMode, acs_pkg::MODE_IDLE);
    check({23'h0, link.dataReadyN}, 24'h1);
    check(link.zeroScaleCoef, acs_pkg::ZS_COEF_RST);
    check(link.fullScaleCoef, acs_pkg::FS_COEF_RST);
    foreach (rows[i])
    begin
      issue(rows[i].mode, rows[i].uni);
      repeat (4) @(negedge clk);
      check({21'h0, link.calMode}, {21'h0, rows[i].mode});
      waitWord(lat, w);
      check(w, rows[i].word);
      // Four edges already waited above count toward the latency
      check({23'h0, lat + 4 >= rows[i].lat && lat + 4 <= rows[i].lat + 8}, 24'h1);
      check({21'h0, link.calMode}, 24'h0);
    end
    // A loaded gain value must survive a later zero-scale step
    @(posedge clk);
    coefLoadZs <= 1'h1;
    coefLoadData <= 24'h000100;
    @(posedge clk);
    coefLoadZs <= 1'h0;
    coefLoadFs <= 1'h1;
    coefLoadData <= 24'h123456;
    @(posedge clk);
    coefLoadFs <= 1'h0;
    @(negedge clk);
    check(link.zeroScaleCoef, 24'h000100);
    issue(acs_pkg::MODE_SYS_ZS, 1'h1);
    waitWord(lat, w);
    check(link.fullScaleCoef, 24'h123456);
    check({23'h0, zsValid}, 24'h1);
    // Background: words six periods apart, mode held until rewritten
    issue(acs_pkg::MODE_BACKGND, 1'h1);
    waitWord(lat, w);
    waitWord(lat, w);
    check({23'h0, lat == 3072}, 24'h1);
    check({21'h0, link.calMode}, {21'h0, acs_pkg::MODE_BACKGND});
    check({23'h0, shortSeen}, 24'h1);
    issue(acs_pkg::MODE_IDLE, 1'h1);
    repeat (4) @(negedge clk);
    check({21'h0, link.calMode}, 24'h0);
    giveVerdict;
  end
  // Watchdog sized well past the expected run of about 24000 cycles
  initial
  begin
    #(60000 * 10);
    errTotal++;
    $display("BAD t=%0t watchdog expired", $time);
    giveVerdict;
  end
endmodule
`default_nettype wire
